// ===== hdl/bbse_exec.sv
// branch, bit and shift execution unit with its wishbone register port
//
// What this block does
// - skip next when io bit one, 1/2/3 cycles
// - flag-one branch: pc plus offset plus one
// - flag-zero branch taken on zero, 1/2 cycles
// - equal on zero one, not-equal on zero zero
// - carry-one and lower branch when carry one
// - carry-zero and same-or-higher branch when carry zero
// - minus on negative one, plus on zero
// - signed ge taken when n xor v zero
// - signed lt taken when n xor v one
// - half carry pair branches on h
// - transfer pair branches on t
// - overflow pair branches on v
// - irq pair branches on global enable
// - set/clear io bit, flags kept, two cycles
// - shift left, zero in, z c n v
// - shift right, zero in, z c n v
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - arithmetic shift right keeps bit seven
// - swap nibbles, no flags, one cycle
// - bit store to t, bit load from t
// - single-cycle set or clear of one flag
`timescale 1ns/10ps
module bbse_exec #(
  parameter int PC_W = 16 // program counter width
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // types and helpers

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } bbse_state_t;

  // byte-lane merge for bus writes
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction : merge_sel

  // opcodes that move the program counter by a relative offset
  function automatic logic is_branch(input logic [5:0] op);
    return (op >= bbse_pkg::OP_BR_FLAG_ONE) && (op <= bbse_pkg::OP_BR_IOFF);
  endfunction : is_branch

  // opcodes that write back the working register
  function automatic logic writes_reg(input logic [5:0] op);
    return (op >= bbse_pkg::OP_SHL && op <= bbse_pkg::OP_SWAP) ||
           (op == bbse_pkg::OP_BLD);
  endfunction : writes_reg

  ////////////////////////////////////////////////////////////////////////////
  // state

  bbse_state_t state;          // sequencer
  logic [1:0] left;            // cycles already spent on the instruction
  logic [31:0] cmd;            // latched command word
  logic [PC_W-1:0] pc;         // program counter
  logic [7:0] status_register;            // status_register
  logic [7:0] gpr [bbse_pkg::REG_COUNT]; // working registers
  logic [7:0] io [bbse_pkg::IO_COUNT];   // io registers
  logic done;                  // sticky completion flag

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic [5:0] op;              // opcode field
  logic [2:0] bsel;            // bit field
  logic [4:0] idx;             // register or io index
  logic [6:0] ofs;             // signed offset
  logic long_next;             // following instruction is two words
  logic io_hit;                // addressed io bit is one
  logic [1:0] need;            // cycles this instruction takes
  logic last;                  // final cycle of the instruction
  logic [PC_W-1:0] next_pc;    // pc after the instruction

  assign op = cmd[bbse_pkg::CF_OP_LO +: 6];
  assign bsel = cmd[bbse_pkg::CF_BIT_LO +: 3];
  assign idx = cmd[bbse_pkg::CF_IDX_LO +: 5];
  assign ofs = cmd[bbse_pkg::CF_OFS_LO +: 7];
  assign long_next = cmd[bbse_pkg::CF_LONG];
  assign io_hit = io[idx][bsel];

  ////////////////////////////////////////////////////////////////////////////
  // helper units

  bbse_unit_if u();

  assign u.op = op;
  assign u.operand = gpr[idx];
  assign u.bit_sel = bsel;
  assign u.status_register = status_register;

  // shifts, swap, bit transfer and flag writes
  bbse_bit_unit bit_unit (
    .u(u.bits)
  );

  // branch conditions
  bbse_cond_unit cond_unit (
    .u(u.cond)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timing and next pc

  // cycle count; a skip costs one more cycle per word skipped
  always_comb begin
    if (is_branch(op)) begin
      need = u.taken ? bbse_pkg::CYC_TWO : bbse_pkg::CYC_ONE;
    end else if (op == bbse_pkg::OP_SKIP_IO_ONE) begin
      if (!io_hit) begin
        need = bbse_pkg::CYC_ONE;
      end else begin
        need = long_next ? bbse_pkg::CYC_THREE : bbse_pkg::CYC_TWO;
      end
    end else if (op == bbse_pkg::OP_SET_IO || op == bbse_pkg::OP_CLR_IO) begin
      need = bbse_pkg::CYC_TWO;
    end else begin
      need = bbse_pkg::CYC_ONE;
    end
  end

  // offset is sign extended so backward targets work
  always_comb begin
    if (is_branch(op) && u.taken) begin
      next_pc = pc + {{(PC_W-7){ofs[6]}}, ofs} + PC_W'(1);
    end else if (op == bbse_pkg::OP_SKIP_IO_ONE && io_hit) begin
      next_pc = pc + (long_next ? PC_W'(3) : PC_W'(2));
    end else begin
      next_pc = pc + PC_W'(1);
    end
  end

  assign last = (state == ST_RUN) && ((left + 2'd1) == need);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;       // request present and not yet answered
  logic wr_fire;   // write takes effect at this edge
  logic issue;     // command write accepted
  logic [31:0] rd; // read data before the output flop

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where ack is seen, as the master expects
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  // a command while busy is dropped; the core is not pipelined
  assign issue = wr_fire && (wb_adr_i == bbse_pkg::A_CMD) && (state == ST_IDLE);

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd = 32'h0000_0000;
    if (wb_adr_i == bbse_pkg::A_CMD) begin
      rd = cmd;
    end else if (wb_adr_i == bbse_pkg::A_STAT) begin
      rd = {30'h0000_0000, done, busy};
    end else if (wb_adr_i == bbse_pkg::A_PC) begin
      rd = 32'(pc);
    end else if (wb_adr_i == bbse_pkg::A_STATUS_REGISTER) begin
      rd = {24'h00_0000, status_register};
    end else if (wb_adr_i[11:7] == bbse_pkg::A_GPR_WIN) begin
      rd = {24'h00_0000, gpr[wb_adr_i[6:2]]};
    end else if (wb_adr_i[11:7] == bbse_pkg::A_IO_WIN) begin
      rd = {24'h00_0000, io[wb_adr_i[6:2]]};
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // latch the command, then count cycles until the final one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      left <= 2'd0;
      busy <= 1'b0;
      cmd <= bbse_pkg::CMD_RST;
    end else begin
      case (state)
        ST_IDLE: begin
          left <= 2'd0;
          if (issue) begin
            cmd <= merge_sel(cmd, wb_dat_i, wb_sel_i);
            state <= ST_RUN;
            busy <= 1'b1;
          end
        end
        ST_RUN: begin
          if (last) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            left <= left + 2'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // completion flag; set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (last) begin
      done <= 1'b1;
    end else if (issue) begin
      done <= 1'b0;
    end else if (wr_fire && wb_adr_i == bbse_pkg::A_STAT && wb_sel_i[0] && wb_dat_i[1]) begin
      done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state

  // program counter; software may only load it while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= '0;
    end else if (last) begin
      pc <= next_pc;
    end else if (wr_fire && wb_adr_i == bbse_pkg::A_PC && state == ST_IDLE) begin
      pc <= PC_W'(merge_sel(32'(pc), wb_dat_i, wb_sel_i));
    end
  end

  // status_register; io bit ops and swap leave it as is through the bit unit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_register <= bbse_pkg::STATUS_REGISTER_RST;
    end else if (last) begin
      status_register <= u.next_status_register;
    end else if (wr_fire && wb_adr_i == bbse_pkg::A_STATUS_REGISTER && state == ST_IDLE) begin
      if (wb_sel_i[0]) begin
        status_register <= wb_dat_i[7:0];
      end
    end
  end

  // working registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < bbse_pkg::REG_COUNT; i++) begin
        gpr[i] <= 8'h00;
      end
    end else if (last && writes_reg(op)) begin
      gpr[idx] <= u.result;
    end else if (wr_fire && wb_adr_i[11:7] == bbse_pkg::A_GPR_WIN && state == ST_IDLE) begin
      if (wb_sel_i[0]) begin
        gpr[wb_adr_i[6:2]] <= wb_dat_i[7:0];
      end
    end
  end

  // io registers; only the addressed bit moves on set or clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < bbse_pkg::IO_COUNT; i++) begin
        io[i] <= 8'h00;
      end
    end else if (last && op == bbse_pkg::OP_SET_IO) begin
      io[idx][bsel] <= 1'b1;
    end else if (last && op == bbse_pkg::OP_CLR_IO) begin
      io[idx][bsel] <= 1'b0;
    end else if (wr_fire && wb_adr_i[11:7] == bbse_pkg::A_IO_WIN && state == ST_IDLE) begin
      if (wb_sel_i[0]) begin
        io[wb_adr_i[6:2]] <= wb_dat_i[7:0];
      end
    end
  end

endmodule : bbse_exec

// ===== hdl/bbse_pkg.sv
// package: opcodes, command fields, flag positions, register map and cycle counts
package bbse_pkg;
  // status flag positions inside the status_register
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  // command word field positions
  localparam int CF_OP_LO = 0;
  localparam int CF_BIT_LO = 8;
  localparam int CF_LONG = 11;
  localparam int CF_IDX_LO = 16;
  localparam int CF_OFS_LO = 24;
  // storage sizes
  localparam int REG_COUNT = 32;
  localparam int IO_COUNT = 32;
  // byte addresses on the bus
  localparam logic [11:0] A_CMD = 12'h0_000;
  localparam logic [11:0] A_STAT = 12'h0_004;
  localparam logic [11:0] A_PC = 12'h0_008;
  localparam logic [11:0] A_STATUS_REGISTER = 12'h0_00C;
  localparam logic [4:0] A_GPR_WIN = 5'h0_001;
  localparam logic [4:0] A_IO_WIN = 5'h0_002;
  // reset values
  localparam logic [7:0] STATUS_REGISTER_RST = 8'h0_0;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // opcodes
  localparam logic [5:0] OP_SKIP_IO_ONE = 6'h01, OP_BR_FLAG_ONE = 6'h02;
  localparam logic [5:0] OP_BR_FLAG_ZERO = 6'h03, OP_BR_EQ = 6'h04, OP_BR_NE = 6'h05;
  localparam logic [5:0] OP_BR_C1 = 6'h06, OP_BR_C0 = 6'h07, OP_BR_SH = 6'h08;
  localparam logic [5:0] OP_BR_LO = 6'h09, OP_BR_MI = 6'h0A, OP_BR_PL = 6'h0B;
  localparam logic [5:0] OP_BR_GE = 6'h0C, OP_BR_LT = 6'h0D, OP_BR_H1 = 6'h0E;
  localparam logic [5:0] OP_BR_H0 = 6'h0F, OP_BR_T1 = 6'h10, OP_BR_T0 = 6'h11;
  localparam logic [5:0] OP_BR_V1 = 6'h12, OP_BR_V0 = 6'h13, OP_BR_ION = 6'h14;
  localparam logic [5:0] OP_BR_IOFF = 6'h15, OP_SET_IO = 6'h18, OP_CLR_IO = 6'h19;
  localparam logic [5:0] OP_SHL = 6'h20, OP_SHR = 6'h21, OP_ROL = 6'h22;
  localparam logic [5:0] OP_ROR = 6'h23, OP_ASR = 6'h24, OP_SWAP = 6'h25;
  localparam logic [5:0] OP_SET_FLAG_INDEXED = 6'h28, OP_CLEAR_FLAG_INDEXED = 6'h29, OP_BST = 6'h2A;
  localparam logic [5:0] OP_BLD = 6'h2B, OP_SEC = 6'h30, OP_CLC = 6'h31;
  localparam logic [5:0] OP_SEN = 6'h32, OP_CLN = 6'h33, OP_SEZ = 6'h34;
  localparam logic [5:0] OP_CLZ = 6'h35, OP_SEI = 6'h36, OP_CLI = 6'h37;
  localparam logic [5:0] OP_SES = 6'h38;
endpackage : bbse_pkg

// ===== hdl/bbse_unit_if.sv
// interface: operands and results shared by the core and its two helper units
`timescale 1ns/10ps
interface bbse_unit_if;
  logic [5:0] op;        // latched opcode
  logic [7:0] operand;   // addressed working register
  logic [2:0] bit_sel;   // bit or flag index
  logic [7:0] status_register;      // current status_register
  logic [7:0] result;    // new register value
  logic [7:0] next_status_register; // new status_register
  logic taken;           // branch condition met
  modport core (output op, operand, bit_sel, status_register, input result, next_status_register, taken);
  modport bits (input op, operand, bit_sel, status_register, output result, next_status_register);
  modport cond (input op, bit_sel, status_register, output taken);
endinterface : bbse_unit_if

// ===== hdl/bbse_cond_unit.sv
// branch condition evaluation on the status flags
`timescale 1ns/10ps
module bbse_cond_unit (
  // shared operands
  bbse_unit_if.cond u
);
  // one flag or flag pair per opcode; anything else never branches
  always_comb begin
    case (u.op)
      bbse_pkg::OP_BR_FLAG_ONE: u.taken = u.status_register[u.bit_sel];
      bbse_pkg::OP_BR_FLAG_ZERO: u.taken = ~u.status_register[u.bit_sel];
      bbse_pkg::OP_BR_EQ: u.taken = u.status_register[bbse_pkg::FL_Z];
      bbse_pkg::OP_BR_NE: u.taken = ~u.status_register[bbse_pkg::FL_Z];
      bbse_pkg::OP_BR_C1, bbse_pkg::OP_BR_LO: u.taken = u.status_register[bbse_pkg::FL_C];
      bbse_pkg::OP_BR_C0, bbse_pkg::OP_BR_SH: u.taken = ~u.status_register[bbse_pkg::FL_C];
      bbse_pkg::OP_BR_MI: u.taken = u.status_register[bbse_pkg::FL_N];
      bbse_pkg::OP_BR_PL: u.taken = ~u.status_register[bbse_pkg::FL_N];
      // signed compare uses n xor v, not the stored sign flag
      bbse_pkg::OP_BR_GE: u.taken = ~(u.status_register[bbse_pkg::FL_N] ^ u.status_register[bbse_pkg::FL_V]);
      bbse_pkg::OP_BR_LT: u.taken = u.status_register[bbse_pkg::FL_N] ^ u.status_register[bbse_pkg::FL_V];
      bbse_pkg::OP_BR_H1: u.taken = u.status_register[bbse_pkg::FL_H];
      bbse_pkg::OP_BR_H0: u.taken = ~u.status_register[bbse_pkg::FL_H];
      bbse_pkg::OP_BR_T1: u.taken = u.status_register[bbse_pkg::FL_T];
      bbse_pkg::OP_BR_T0: u.taken = ~u.status_register[bbse_pkg::FL_T];
      bbse_pkg::OP_BR_V1: u.taken = u.status_register[bbse_pkg::FL_V];
      bbse_pkg::OP_BR_V0: u.taken = ~u.status_register[bbse_pkg::FL_V];
      bbse_pkg::OP_BR_ION: u.taken = u.status_register[bbse_pkg::FL_I];
      bbse_pkg::OP_BR_IOFF: u.taken = ~u.status_register[bbse_pkg::FL_I];
      default: u.taken = 1'b0;
    endcase
  end
endmodule : bbse_cond_unit

// ===== hdl/bbse_bit_unit.sv
// shift, rotate, swap, bit transfer and flag set/clear datapath
`timescale 1ns/10ps
module bbse_bit_unit (
  // shared operands
  bbse_unit_if.bits u
);
  logic [7:0] r;  // result
  logic [7:0] f;  // flags
  logic c_out;    // carry after a shift
  logic shifted;  // shift family updates z,c,n,v
  // result and flag choice; untouched values pass through
  always_comb begin
    r = u.operand;
    f = u.status_register;
    c_out = u.status_register[bbse_pkg::FL_C];
    shifted = 1'b0;
    case (u.op)
      bbse_pkg::OP_SHL: begin
        r = {u.operand[6:0], 1'b0};
        c_out = u.operand[7];
        shifted = 1'b1;
      end
      bbse_pkg::OP_SHR: begin
        r = {1'b0, u.operand[7:1]};
        c_out = u.operand[0];
        shifted = 1'b1;
      end
      bbse_pkg::OP_ROL: begin
        r = {u.operand[6:0], u.status_register[bbse_pkg::FL_C]};
        c_out = u.operand[7];
        shifted = 1'b1;
      end
      bbse_pkg::OP_ROR: begin
        r = {u.status_register[bbse_pkg::FL_C], u.operand[7:1]};
        c_out = u.operand[0];
        shifted = 1'b1;
      end
      bbse_pkg::OP_ASR: begin
        r = {u.operand[7], u.operand[7:1]};
        c_out = u.operand[0];
        shifted = 1'b1;
      end
      bbse_pkg::OP_SWAP: r = {u.operand[3:0], u.operand[7:4]};
      bbse_pkg::OP_BST: f[bbse_pkg::FL_T] = u.operand[u.bit_sel];
      bbse_pkg::OP_BLD: r[u.bit_sel] = u.status_register[bbse_pkg::FL_T];
      bbse_pkg::OP_SET_FLAG_INDEXED: f[u.bit_sel] = 1'b1;
      bbse_pkg::OP_CLEAR_FLAG_INDEXED: f[u.bit_sel] = 1'b0;
      bbse_pkg::OP_SEC: f[bbse_pkg::FL_C] = 1'b1;
      bbse_pkg::OP_CLC: f[bbse_pkg::FL_C] = 1'b0;
      bbse_pkg::OP_SEN: f[bbse_pkg::FL_N] = 1'b1;
      bbse_pkg::OP_CLN: f[bbse_pkg::FL_N] = 1'b0;
      bbse_pkg::OP_SEZ: f[bbse_pkg::FL_Z] = 1'b1;
      bbse_pkg::OP_CLZ: f[bbse_pkg::FL_Z] = 1'b0;
      bbse_pkg::OP_SEI: f[bbse_pkg::FL_I] = 1'b1;
      bbse_pkg::OP_CLI: f[bbse_pkg::FL_I] = 1'b0;
      bbse_pkg::OP_SES: f[bbse_pkg::FL_S] = 1'b1;
      default: r = u.operand;
    endcase
    // v follows n xor c, as after any one-place shift
    if (shifted) begin
      f[bbse_pkg::FL_C] = c_out;
      f[bbse_pkg::FL_Z] = (r == 8'h00);
      f[bbse_pkg::FL_N] = r[7];
      f[bbse_pkg::FL_V] = r[7] ^ c_out;
    end
  end
  assign u.result = r;
  assign u.next_status_register = f;
endmodule : bbse_bit_unit

// ===== dv/bbse_exec_chk.sv
// checker: bus handshake and execution timing of the branch/bit/shift unit
`timescale 1ns/10ps
module bbse_exec_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // status
  input wire logic busy
);
  // one clock domain, so one default clock and reset
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // accepted full-word command write while idle
  sequence s_cmd_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !busy &&
      wb_adr_i == bbse_pkg::A_CMD && wb_sel_i == 4'hf;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_cmd_busy;
    s_cmd_wr |=> busy;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("command did not start");
  // the longest instruction here is a skip over a long word
  property p_busy_bound;
    $rose(busy) |-> ##[1:3] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_busy_cause;
    $rose(busy) |-> $past(wb_cyc_i && wb_we_i && wb_ack_o && wb_adr_i == bbse_pkg::A_CMD);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  property p_hole_zero;
    s_req and (!wb_we_i && wb_adr_i == 12'h010) |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  property p_dat_hold;
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed idle");
endmodule : bbse_exec_chk
bind bbse_exec bbse_exec_chk chk_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy));

// ===== dv/tb.sv
// testbench: instruction-level tests of the branch/bit/shift unit over its bus
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  // clock, reset and bus master signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0] sel = 4'hf; // always full words
  logic [31:0] rdat;
  logic ack;
  logic busy;
  int n_fail = 0;
  int check_count = 0;
  // branch table by opcode 02..15: flag watched and level that takes it
  int fl[20] = '{5, 5, 1, 1, 0, 0, 0, 0, 2, 2, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
  int pol[20] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};
  // named flag ops 30..38: flag touched
  int nf[9] = '{0, 0, 2, 2, 1, 1, 7, 7, 4};
  logic [7:0] av[3] = '{8'h81, 8'h40, 8'h01};
  always #50 clk = ~clk;
  bbse_exec dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .busy(busy));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // one classic cycle; read data is taken at the ack edge, bounded wait
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_fail++;
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask : rdc
  // issue a command and count the cycles busy stays high
  task automatic run(input logic [31:0] c, input int n);
    int k;
    wr(bbse_pkg::A_CMD, c);
    k = 0;
    while (busy === 1'b1 && k < 8) begin
      k++;
      @(posedge clk);
    end
    `CHK(k, n)
    if (k >= 8) begin
      end_sim();
    end
  endtask : run
  function automatic logic [31:0] mk(input logic [5:0] op, input logic [2:0] b,
      input logic lg, input logic [4:0] ix, input logic [6:0] of);
    return {1'b0, of, 3'b000, ix, 4'h0, lg, b, 2'b00, op};
  endfunction : mk
  function automatic logic [11:0] gpr(input logic [4:0] i);
    return {bbse_pkg::A_GPR_WIN, i, 2'b00};
  endfunction : gpr
  function automatic logic [11:0] iop(input logic [4:0] i);
    return {bbse_pkg::A_IO_WIN, i, 2'b00};
  endfunction : iop
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] s, m, r, e8;
    logic c, tk, cy, co;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and an unmapped hole
    rdc(bbse_pkg::A_PC, 32'h0000_0000);
    rdc(bbse_pkg::A_STATUS_REGISTER, 32'h0000_0000);
    rdc(iop(5'h00), 32'h0000_0000);
    wr(12'h010, 32'hffff_ffff);
    rdc(12'h010, 32'h0000_0000);
    // every conditional branch, both senses; even opcodes forward, odd ones backward
    for (int k = 0; k < 20; k++) begin
      for (int p = 0; p < 4; p++) begin
        m = 8'h01 << fl[k];
        s = p[1] ? m : 8'h00;
        if (p[0]) s = ~s;
        c = (k == 10 || k == 11) ? s[2] ^ s[3] : s[fl[k]];
        tk = (c == pol[k][0]);
        wr(bbse_pkg::A_STATUS_REGISTER, 32'(s));
        wr(bbse_pkg::A_PC, 32'h0000_0100);
        run(mk(6'(k + 2), 3'(fl[k]), 1'b0, 5'h00, k[0] ? 7'h7b : 7'h03), tk ? 2 : 1);
        rdc(bbse_pkg::A_PC, tk ? (k[0] ? 32'h0000_00fc : 32'h0000_0104) : 32'h0000_0101);
        rdc(bbse_pkg::A_STATUS_REGISTER, 32'(s));
      end
    end
    // skip on io bit: short skip, long skip, not taken
    wr(iop(5'h03), 32'h0000_0040);
    wr(bbse_pkg::A_PC, 32'h0000_0200);
    run(mk(bbse_pkg::OP_SKIP_IO_ONE, 3'h6, 1'b0, 5'h03, 7'h00), 2);
    run(mk(bbse_pkg::OP_SKIP_IO_ONE, 3'h6, 1'b1, 5'h03, 7'h00), 3);
    run(mk(bbse_pkg::OP_SKIP_IO_ONE, 3'h5, 1'b1, 5'h03, 7'h00), 1);
    rdc(bbse_pkg::A_PC, 32'h0000_0206);
    rdc(bbse_pkg::A_STAT, 32'h0000_0002);
    wr(bbse_pkg::A_STAT, 32'h0000_0002);
    rdc(bbse_pkg::A_STAT, 32'h0000_0000);
    // io bit set and clear keep the flags
    wr(bbse_pkg::A_STATUS_REGISTER, 32'h0000_005a);
    wr(iop(5'h05), 32'h0000_00a5);
    run(mk(bbse_pkg::OP_SET_IO, 3'h1, 1'b0, 5'h05, 7'h00), 2);
    rdc(iop(5'h05), 32'h0000_00a7);
    run(mk(bbse_pkg::OP_CLR_IO, 3'h7, 1'b0, 5'h05, 7'h00), 2);
    rdc(iop(5'h05), 32'h0000_0027);
    rdc(bbse_pkg::A_STATUS_REGISTER, 32'h0000_005a);
    // shifts, rotates and swap over operands and carry-in
    for (int j = 0; j < 6; j++) begin
      for (int i = 0; i < 6; i++) begin
        cy = i[0];
        s = 8'ha4 | {7'h00, cy};
        case (j)
          0: r = {av[i / 2][6:0], 1'b0};
          1: r = {1'b0, av[i / 2][7:1]};
          2: r = {av[i / 2][6:0], cy};
          3: r = {cy, av[i / 2][7:1]};
          4: r = {av[i / 2][7], av[i / 2][7:1]};
          default: r = {av[i / 2][3:0], av[i / 2][7:4]};
        endcase
        co = (j == 0 || j == 2) ? av[i / 2][7] : av[i / 2][0];
        e8 = s;
        if (j != 5) begin
          e8[bbse_pkg::FL_C] = co;
          e8[bbse_pkg::FL_Z] = (r == 8'h00);
          e8[bbse_pkg::FL_N] = r[7];
          e8[bbse_pkg::FL_V] = r[7] ^ co;
        end
        wr(gpr(5'h07), 32'(av[i / 2]));
        wr(bbse_pkg::A_STATUS_REGISTER, 32'(s));
        run(mk(6'(j + 32), 3'h0, 1'b0, 5'h07, 7'h00), 1);
        rdc(gpr(5'h07), 32'(r));
        rdc(bbse_pkg::A_STATUS_REGISTER, 32'(e8));
      end
    end
    // bit store and bit load through the transfer flag
    wr(gpr(5'h02), 32'h0000_0010);
    wr(bbse_pkg::A_STATUS_REGISTER, 32'h0000_0000);
    run(mk(bbse_pkg::OP_BST, 3'h4, 1'b0, 5'h02, 7'h00), 1);
    rdc(bbse_pkg::A_STATUS_REGISTER, 32'h0000_0040);
    run(mk(bbse_pkg::OP_BLD, 3'h0, 1'b0, 5'h02, 7'h00), 1);
    rdc(gpr(5'h02), 32'h0000_0011);
    run(mk(bbse_pkg::OP_BST, 3'h1, 1'b0, 5'h02, 7'h00), 1);
    run(mk(bbse_pkg::OP_BLD, 3'h4, 1'b0, 5'h02, 7'h00), 1);
    rdc(gpr(5'h02), 32'h0000_0001);
    rdc(bbse_pkg::A_STATUS_REGISTER, 32'h0000_0000);
    // indexed and named flag set and clear touch one flag only
    for (int b = 0; b < 8; b++) begin
      wr(bbse_pkg::A_STATUS_REGISTER, 32'h0000_0000);
      run(mk(bbse_pkg::OP_SET_FLAG_INDEXED, 3'(b), 1'b0, 5'h00, 7'h00), 1);
      rdc(bbse_pkg::A_STATUS_REGISTER, 32'(8'h01 << b));
      wr(bbse_pkg::A_STATUS_REGISTER, 32'h0000_00ff);
      run(mk(bbse_pkg::OP_CLEAR_FLAG_INDEXED, 3'(b), 1'b0, 5'h00, 7'h00), 1);
      rdc(bbse_pkg::A_STATUS_REGISTER, {24'h00_0000, ~(8'h01 << b)});
    end
    for (int j = 0; j < 9; j++) begin
      s = j[0] ? 8'hff : 8'h00;
      e8 = s;
      e8[nf[j]] = ~j[0];
      wr(bbse_pkg::A_STATUS_REGISTER, 32'(s));
      run(mk(6'(j + 48), 3'h0, 1'b0, 5'h00, 7'h00), 1);
      rdc(bbse_pkg::A_STATUS_REGISTER, 32'(e8));
    end
    // reset in the middle of an instruction
    wr(bbse_pkg::A_CMD, mk(bbse_pkg::OP_SET_IO, 3'h0, 1'b0, 5'h05, 7'h00));
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(bbse_pkg::A_PC, 32'h0000_0000);
    rdc(iop(5'h05), 32'h0000_0000);
    rdc(bbse_pkg::A_STAT, 32'h0000_0000);
    end_sim();
  end
endmodule : tb
